// ===== rtl/pll_lock_cp_consts.svh
// Offsets, fields, reset values and step sizes of the PLL control bank
// What this block does
// - Lock after chosen count of consecutive in-window samples, 5 to 65535.
// - Training starts on a 0-to-1 edge of the training bit only.
// - Cycle slip guard adds about 6 mA for each large-phase-error cycle.
// - Pin off when pin enable is 0; otherwise driven when companion bit is 1.
// - Without companion bit, serial output off unless chip address is 000.
// - Oscillator bias follows its bit, only with the external oscillator.
// - Level bit picks 1.8 V (0) or 3 V supply (1) on the pin.
// - Down gain sets 20 uA per code, 0 to 2.54 mA.
// - Up gain sets 20 uA per code, 0 to maximum at 127.
// - Offset magnitude sets 5 uA per code, 0 to 635 uA.
// - Separate bits apply the offset upward (21) and downward (22).
// - High-gain mode adds about 3 mA of pump current.
// - Lock detect register resets to default, detection and guard on.
`ifndef PLL_LOCK_CP_CONSTS_SVH
`define PLL_LOCK_CP_CONSTS_SVH

// Register offsets on the programming port
`define LOCK_DETECT_CONFIG_OFS 6'h07
`define ANALOG_ENABLE_CONFIG_OFS 6'h08
`define CHARGE_PUMP_CONFIG_OFS 6'h09

// Reset values
`define LOCK_DETECT_CONFIG_RST 24'h200844
`define ANALOG_ENABLE_CONFIG_RST 24'h01BFFF
`define CHARGE_PUMP_CONFIG_RST 24'h547264

// Lock detect register fields
`define LOCK_WIN_LSB 0
`define LOCK_WIN_MSB 2
`define LOCK_ENABLE_BIT 11
`define LOCK_TRAIN_BIT 20
`define LOCK_SLIP_BIT 21

// Consecutive in-window counts for window codes 0 to 7
`define LOCK_CNT_CODE0 16'h0005
`define LOCK_CNT_CODE1 16'h0020
`define LOCK_CNT_CODE2 16'h0060
`define LOCK_CNT_CODE3 16'h0100
`define LOCK_CNT_CODE4 16'h0200
`define LOCK_CNT_CODE5 16'h0800
`define LOCK_CNT_CODE6 16'h2000
`define LOCK_CNT_CODE7 16'hFFFF

// Analog enable register fields
`define AE_PIN_EN_BIT 5
`define AE_BIAS_BIT 10
`define AE_HF_REF_BIT 21
`define AE_LEVEL_BIT 22

// Pump current steps in microamps
`define PUMP_GAIN_STEP_UA 14'h0014
`define PUMP_OFFSET_STEP_UA 14'h0005
`define PUMP_HIGH_GAIN_UA 14'h0BB8
`define PUMP_SLIP_BOOST_UA 14'h1770

`endif

// ===== rtl/pll_lock_cp_pkg.sv
// Types shared by the PLL control bank
package pll_lock_cp_pkg;

  // Charge pump register layout, bit 23 down to bit 0
  typedef struct packed {
    logic high_gain_pump_mode;
    logic offset_dn_en;
    logic offset_up_en;
    logic [6:0] offset_mag;
    logic [6:0] up_gain;
    logic [6:0] dn_gain;
  } charge_pump_cfg_s;

  // Pump drive toward the analog core
  typedef struct packed {
    logic [13:0] up_ua;
    logic [13:0] dn_ua;
  } charge_pump_drive_s;

  // Lock detector states
  typedef enum logic [1:0] {
    LOCK_OFF,
    LOCK_SEEK,
    LOCK_HELD
  } lock_state_e;

endpackage

// ===== rtl/pll_lock_cp_control_regs.sv
// Lock detect, analog enable and charge pump control registers
`timescale 1ns/1ps
`include "pll_lock_cp_consts.svh"

module pll_lock_cp_control_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port from the serial shifter
  input wire logic wr_en_i,
  input wire logic [5:0] wr_addr_i,
  input wire logic [23:0] wr_data_i,
  input wire logic [5:0] rd_addr_i,
  output logic [23:0] rd_data_o,
  // Lock detector inputs from the phase detector
  input wire logic sample_i,
  input wire logic in_window_i,
  input wire logic phase_err_large_i,
  // Context from other registers and straps
  input wire logic force_drive_i,
  input wire logic [2:0] chip_addr_i,
  input wire logic ext_osc_sel_i,
  input wire logic serial_data_i,
  // Lock detector outputs
  output logic lock_indicator_o,
  output logic train_start_o,
  // Lock or serial output pin
  output logic lock_or_serial_out_pin_o,
  output logic lock_or_serial_out_pin_oe_n_o,
  output logic digital_3v_supply_sel_o,
  // Analog controls
  output logic bias_en_o,
  output logic reference_crystal_hf_o,
  output logic cycle_slip_boost_o,
  output pll_lock_cp_pkg::charge_pump_drive_s charge_pump_o
);

  logic [23:0] lock_detect_config_q;
  logic [23:0] analog_enable_config_q;
  pll_lock_cp_pkg::charge_pump_cfg_s charge_pump_config_q;
  pll_lock_cp_pkg::lock_state_e lock_state_q;
  logic [15:0] win_cnt_q;
  logic train_prev_q;
  logic lock_en;
  logic train_bit;
  logic slip_en;
  logic pin_en;
  logic [2:0] win_code;
  logic [16:0] cnt_next;

  // Consecutive count needed for each window code
  function automatic logic [15:0] lock_target(input logic [2:0] code);
    logic [15:0] t;
    t = `LOCK_CNT_CODE0;
    unique case (code)
      3'h0: t = `LOCK_CNT_CODE0;
      3'h1: t = `LOCK_CNT_CODE1;
      3'h2: t = `LOCK_CNT_CODE2;
      3'h3: t = `LOCK_CNT_CODE3;
      3'h4: t = `LOCK_CNT_CODE4;
      3'h5: t = `LOCK_CNT_CODE5;
      3'h6: t = `LOCK_CNT_CODE6;
      3'h7: t = `LOCK_CNT_CODE7;
    endcase
    return t;
  endfunction

  // Pump current in microamps for one direction
  function automatic logic [13:0] pump_ua(input logic [6:0] gain,
                                          input logic off_en,
                                          input logic [6:0] mag,
                                          input logic high_gain,
                                          input logic boost);
    logic [13:0] ua;
    ua = 14'(gain) * `PUMP_GAIN_STEP_UA;
    if (off_en) begin
      ua = ua + 14'(mag) * `PUMP_OFFSET_STEP_UA;
    end
    if (high_gain) begin
      ua = ua + `PUMP_HIGH_GAIN_UA;
    end
    if (boost) begin
      ua = ua + `PUMP_SLIP_BOOST_UA;
    end
    return ua;
  endfunction

  // Field taps
  assign lock_en = lock_detect_config_q[`LOCK_ENABLE_BIT];
  assign train_bit = lock_detect_config_q[`LOCK_TRAIN_BIT];
  assign slip_en = lock_detect_config_q[`LOCK_SLIP_BIT];
  assign pin_en = analog_enable_config_q[`AE_PIN_EN_BIT];
  assign win_code = lock_detect_config_q[`LOCK_WIN_MSB:`LOCK_WIN_LSB];
  assign cnt_next = {1'b0, win_cnt_q} + 17'h00001;

  // Register writes; unmapped offsets are ignored
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_detect_config_q <= `LOCK_DETECT_CONFIG_RST;
      analog_enable_config_q <= `ANALOG_ENABLE_CONFIG_RST;
      charge_pump_config_q <= `CHARGE_PUMP_CONFIG_RST;
    end else if (wr_en_i) begin
      unique case (wr_addr_i)
        `LOCK_DETECT_CONFIG_OFS: lock_detect_config_q <= wr_data_i;
        `ANALOG_ENABLE_CONFIG_OFS: analog_enable_config_q <= wr_data_i;
        `CHARGE_PUMP_CONFIG_OFS: charge_pump_config_q <= wr_data_i;
        default: ;
      endcase
    end
  end

  // Readback, registered; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= 24'h000000;
    end else begin
      unique case (rd_addr_i)
        `LOCK_DETECT_CONFIG_OFS: rd_data_o <= lock_detect_config_q;
        `ANALOG_ENABLE_CONFIG_OFS: rd_data_o <= analog_enable_config_q;
        `CHARGE_PUMP_CONFIG_OFS: rd_data_o <= charge_pump_config_q;
        default: rd_data_o <= 24'h000000;
      endcase
    end
  end

  // Training edge detect; a held bit gives only one pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      train_prev_q <= 1'b0;
      train_start_o <= 1'b0;
    end else begin
      train_prev_q <= train_bit;
      train_start_o <= train_bit & ~train_prev_q;
    end
  end

  // Lock detector; counter saturates so a long run never wraps into unlock
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_state_q <= pll_lock_cp_pkg::LOCK_OFF;
      win_cnt_q <= 16'h0000;
      lock_indicator_o <= 1'b0;
    end else if (!lock_en) begin
      lock_state_q <= pll_lock_cp_pkg::LOCK_OFF;
      win_cnt_q <= 16'h0000;
      lock_indicator_o <= 1'b0;
    end else if (train_start_o) begin
      // Retraining after a rate change restarts the hunt
      lock_state_q <= pll_lock_cp_pkg::LOCK_SEEK;
      win_cnt_q <= 16'h0000;
      lock_indicator_o <= 1'b0;
    end else if (sample_i) begin
      if (!in_window_i) begin
        lock_state_q <= pll_lock_cp_pkg::LOCK_SEEK;
        win_cnt_q <= 16'h0000;
        lock_indicator_o <= 1'b0;
      end else begin
        if (!cnt_next[16]) begin
          win_cnt_q <= cnt_next[15:0];
        end
        if (cnt_next >= {1'b0, lock_target(win_code)}) begin
          lock_state_q <= pll_lock_cp_pkg::LOCK_HELD;
          lock_indicator_o <= 1'b1;
        end else begin
          lock_state_q <= pll_lock_cp_pkg::LOCK_SEEK;
        end
      end
    end else if (lock_state_q == pll_lock_cp_pkg::LOCK_OFF) begin
      lock_state_q <= pll_lock_cp_pkg::LOCK_SEEK;
    end
  end

  // Pin drive; shared serial bus is left to the part at address 000
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_or_serial_out_pin_oe_n_o <= 1'b1;
      lock_or_serial_out_pin_o <= 1'b0;
      digital_3v_supply_sel_o <= 1'b0;
    end else begin
      if (!pin_en) begin
        lock_or_serial_out_pin_oe_n_o <= 1'b1;
      end else if (force_drive_i) begin
        lock_or_serial_out_pin_oe_n_o <= 1'b0;
      end else begin
        lock_or_serial_out_pin_oe_n_o <= (chip_addr_i != 3'h0);
      end
      lock_or_serial_out_pin_o <= force_drive_i ? lock_indicator_o
                                                : serial_data_i;
      digital_3v_supply_sel_o <= analog_enable_config_q[`AE_LEVEL_BIT];
    end
  end

  // Analog enables and pump drive, registered toward the core
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bias_en_o <= 1'b0;
      reference_crystal_hf_o <= 1'b0;
      cycle_slip_boost_o <= 1'b0;
      charge_pump_o <= '0;
    end else begin
      bias_en_o <= analog_enable_config_q[`AE_BIAS_BIT] & ext_osc_sel_i;
      reference_crystal_hf_o <= analog_enable_config_q[`AE_HF_REF_BIT];
      cycle_slip_boost_o <= slip_en & phase_err_large_i;
      charge_pump_o.up_ua <= pump_ua(charge_pump_config_q.up_gain,
                                     charge_pump_config_q.offset_up_en,
                                     charge_pump_config_q.offset_mag,
                                     charge_pump_config_q.high_gain_pump_mode,
                                     slip_en & phase_err_large_i);
      charge_pump_o.dn_ua <= pump_ua(charge_pump_config_q.dn_gain,
                                     charge_pump_config_q.offset_dn_en,
                                     charge_pump_config_q.offset_mag,
                                     charge_pump_config_q.high_gain_pump_mode,
                                     slip_en & phase_err_large_i);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Count after the lock edge must have reached the target of the code
  chk_lock_needs_run: assert property ($rose(lock_indicator_o) |->
    $past(sample_i && in_window_i) &&
    win_cnt_q >= lock_target($past(win_code)))
    else $error("lock without run");
  chk_window_miss: assert property (sample_i && !in_window_i
    |=> !lock_indicator_o && win_cnt_q == 16'h0000)
    else $error("miss did not restart");
  chk_lock_disabled: assert property (!lock_en |=> !lock_indicator_o)
    else $error("lock shown while disabled");
  chk_train_edge: assert property (train_start_o |->
    $past(train_bit, 1) && !$past(train_bit, 2)) else $error("bad train");
  chk_train_single: assert property (train_start_o |=> !train_start_o)
    else $error("train retriggered");
  chk_pin_off: assert property (!pin_en |=>
    lock_or_serial_out_pin_oe_n_o) else $error("pin driven while off");
  chk_pin_shared: assert property (pin_en && !force_drive_i &&
    chip_addr_i != 3'h0 |=> lock_or_serial_out_pin_oe_n_o)
    else $error("shared bus not released");
  chk_slip_boost: assert property (cycle_slip_boost_o ==
    $past(slip_en && phase_err_large_i)) else $error("slip boost wrong");
  chk_bias_gate: assert property (!ext_osc_sel_i |=> !bias_en_o)
    else $error("bias on with internal oscillator");
  chk_pump_zero: assert property (charge_pump_config_q == '0 &&
    !phase_err_large_i |=> charge_pump_o == '0) else $error("pump not zero");
  // Looked at on the first edge after release, when history is known
  chk_reset_value: assert property (disable iff (1'b0)
    !srst_i && $past(srst_i) |->
    lock_detect_config_q == `LOCK_DETECT_CONFIG_RST)
    else $error("bad lock reset value");

  cov_lock_reached: cover property ($rose(lock_indicator_o));
  cov_lock_lost: cover property ($fell(lock_indicator_o) && lock_en);
  cov_train: cover property (train_start_o);
  cov_boost: cover property (cycle_slip_boost_o);

endmodule

// ===== sim/pll_host_model.sv
// Serial host model that programs the control bank
`timescale 1ns/1ps
module pll_host_model (
  // Clock
  input wire logic clk_i,
  // Register write port
  output logic wr_en_o,
  output logic [5:0] wr_addr_o,
  output logic [23:0] wr_data_o
);
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 6'h3F;
    wr_data_o = 24'h000000;
  end
  // One-cycle strobe; idle bus shows inverted values, not stale ones
  task automatic write_reg(input logic [5:0] a, input logic [23:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask
  // Retrain after a detector rate change: training bit low, then high
  task automatic retrain(input logic [23:0] d);
    write_reg(6'h07, d & 24'hEFFFFF);
    write_reg(6'h07, d | 24'h100000);
  endtask
  // Reference select is only set for fast crystals
  function automatic logic hf_ref(input int mhz);
    return mhz > 200;
  endfunction
endmodule

// ===== sim/pll_lock_cp_control_regs_tb.sv
// Self-checking bench for the PLL control register bank
`timescale 1ns/1ps
`include "pll_lock_cp_consts.svh"
module pll_lock_cp_control_regs_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [23:0] wr_data;
  logic [5:0] rd_addr = 6'h00;
  logic [23:0] rd_data;
  logic sample = 1'b0;
  logic in_win = 1'b0;
  logic perr = 1'b0;
  logic force_drv = 1'b0;
  logic [2:0] chip = 3'h0;
  logic ext = 1'b0;
  logic sdata = 1'b0;
  logic lock, train, pin, oe_n, lvl, bias, hf, boost;
  pll_lock_cp_pkg::charge_pump_drive_s pump_drv;
  logic [31:0] seed = 32'h00004D8D;
  int n_mismatch = 0;
  int num_checks = 0;
  int wins[8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};

  pll_host_model u_host (.clk_i(clk_i), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  pll_lock_cp_control_regs u_dut (.clk_i(clk_i), .srst_i(srst_i),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .sample_i(sample),
    .in_window_i(in_win), .phase_err_large_i(perr),
    .force_drive_i(force_drv), .chip_addr_i(chip), .ext_osc_sel_i(ext),
    .serial_data_i(sdata), .lock_indicator_o(lock), .train_start_o(train),
    .lock_or_serial_out_pin_o(pin), .lock_or_serial_out_pin_oe_n_o(oe_n),
    .digital_3v_supply_sel_o(lvl), .bias_en_o(bias),
    .reference_crystal_hf_o(hf), .cycle_slip_boost_o(boost),
    .charge_pump_o(pump_drv));

  // 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected pump current in microamps for one direction
  function automatic logic [13:0] pump(input logic [6:0] g, input logic en,
      input logic [6:0] m, input logic hg, input logic bst);
    return 14'(g) * 14'h0014 + (en ? 14'(m) * 14'h0005 : 14'h0000)
      + (hg ? 14'h0BB8 : 14'h0000) + (bst ? 14'h1770 : 14'h0000);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    @(negedge clk_i);
    rd_addr = a;
    @(negedge clk_i);
    check("rd_data", {8'h00, rd_data}, {8'h00, exp});
  endtask

  // Sample pulses, then one idle cycle so the registered lock settles
  task automatic samples(input int n, input logic w);
    repeat (n) begin
      @(negedge clk_i);
      sample = 1'b1;
      in_win = w;
    end
    @(negedge clk_i);
    sample = 1'b0;
    in_win = ~w;
    @(negedge clk_i);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run is near 80000 cycles, mostly the longest window; 90000 means a hang
  initial begin
    #360000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic [23:0] d7, d8, d9;
    repeat (6) @(negedge clk_i);
    srst_i = 1'b0;
    rd(`LOCK_DETECT_CONFIG_OFS, `LOCK_DETECT_CONFIG_RST);
    rd(`ANALOG_ENABLE_CONFIG_OFS, `ANALOG_ENABLE_CONFIG_RST);
    rd(`CHARGE_PUMP_CONFIG_OFS, `CHARGE_PUMP_CONFIG_RST);
    rd(6'h0A, 24'h000000);
    $display("test reset done");
    // Training fires on the rising edge only, not on a repeat write
    u_host.retrain(24'h200800);
    @(negedge clk_i);
    check("train", train, 1);
    @(negedge clk_i);
    check("train", train, 0);
    u_host.write_reg(6'h07, 24'h300800);
    repeat (2) @(negedge clk_i);
    check("train", train, 0);
    $display("test training done");
    // Lock needs exactly the selected count; a miss restarts it
    for (int c = 7; c >= 0; c--) begin
      u_host.write_reg(6'h07, 24'h200800 | 24'(c));
      samples(1, 1'b0);
      check("lock", lock, 0);
      samples(wins[c] - 1, 1'b1);
      check("lock", lock, 0);
      samples(1, 1'b1);
      check("lock", lock, 1);
    end
    samples(1, 1'b0);
    check("lock", lock, 0);
    // A miss inside the run must restart the count from zero
    samples(4, 1'b1);
    samples(1, 1'b0);
    samples(4, 1'b1);
    check("lock", lock, 0);
    samples(1, 1'b1);
    check("lock", lock, 1);
    u_host.write_reg(6'h07, 24'h200000);
    @(negedge clk_i);
    check("lock", lock, 0);
    $display("test lock done");
    // Random settings with the all-ones and all-zero charge pump corners first
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      d7 = 24'(rnd()) & 24'hEFF7FF;
      d8 = 24'(rnd());
      d8[21] = u_host.hf_ref(int'(r[15:8]) * 2);
      d9 = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000000 : 24'(rnd());
      perr = r[0];
      force_drv = r[1];
      chip = r[4:2] & {3{r[5]}};
      ext = r[6];
      sdata = r[7];
      u_host.write_reg(6'h07, d7);
      u_host.write_reg(6'h08, d8);
      u_host.write_reg(6'h09, d9);
      rd(6'h07, d7);
      rd(6'h08, d8);
      rd(6'h09, d9);
      check("oe_n", oe_n, !d8[5] ? 1 : !force_drv && chip != 3'h0);
      check("bias", bias, d8[10] & ext);
      check("level", lvl, d8[22]);
      check("hf_ref", hf, d8[21]);
      check("boost", boost, d7[21] & perr);
      // Detection is off here, so forced pin data shows no lock
      check("pin", pin, force_drv ? 1'b0 : sdata);
      check("pump_up", pump_drv.up_ua, pump(d9[13:7], d9[21], d9[20:14],
        d9[23], d7[21] & perr));
      check("pump_dn", pump_drv.dn_ua, pump(d9[6:0], d9[22], d9[20:14],
        d9[23], d7[21] & perr));
    end
    $display("test random done");
    print_verdict();
  end
endmodule
